// ===== rtl/adtt_pkg.sv
// Purpose: Constants and types for the memory throughput tester controller
// Assumes: 20 MHz sys_clk, 64-bit AXI data path, 12-bit APB config space
// Notes: Config offsets are local choices; timing values are the tuned set
// Contract
// - Timing settings are memory clock counts
// - Tuned timing values loaded as given
// - Configure over APB before AXI access
// - Sequencer is APB master writing values
// - Settle 200 us before memory use
// - Fabric clock near 166.6 MHz; code assumes a 20 MHz sys_clk (CLK_HZ)
// - Commands yield read, write, size controls
// - Operations start only on commands
// - Takes command, burst lengths, address, data; code takes only a command word with start, direction and size code
// - Writes use incrementing data pattern
// - Write addresses from zero, step 128
// - Read addresses from zero, step 128
// - Write count first AWVALID to last WLAST
// - Read count first ARVALID to last RLAST
// - Read mismatch drives active-low error
// - Count returned to host per operation
// - Next write address without awaiting response
// - AXI bursts are 16 beats
// - Memory clock twice fabric clock
package adtt_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int SETTLE_US = 200;
	localparam logic [12:0] SETTLE_CYC = 13'(SETTLE_US * (CLK_HZ / 1_000_000));
	localparam logic [31:0] BURST_BYTES = 32'h0000_0080;
	localparam logic [7:0] AXI_LEN = 8'h0F;
	localparam logic [2:0] AXI_SIZE = 3'h3;
	localparam logic [1:0] AXI_INCR = 2'h1;
	localparam logic [3:0] LAST_BEAT = 4'hF;
	localparam logic [8:0] MIN_BURSTS = 9'h010;
	localparam logic [2:0] MAX_SIZE_CODE = 3'h4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_COUNT = 4'h8;
	localparam logic [3:0] REG_BURSTS = 4'hC;
	localparam int CTRL_START = 0;
	localparam int CTRL_DIR = 1;
	localparam int CTRL_SIZE_LSB = 2;
	localparam logic [3:0] N_CFG = 4'hB;
	localparam logic [11:0] CFG_BASE = 12'h000;
	localparam logic [31:0] T_CAS = 32'h5;
	localparam logic [31:0] T_RAS_MIN = 32'hC;
	localparam logic [31:0] T_RAS_MAX = 32'h5800;
	localparam logic [31:0] T_RCD = 32'h5;
	localparam logic [31:0] T_RP = 32'h5;
	localparam logic [31:0] T_REFI = 32'hA20;
	localparam logic [31:0] T_RC = 32'h11;
	localparam logic [31:0] T_RFC = 32'h36;
	localparam logic [31:0] T_WR = 32'h5;
	localparam logic [31:0] T_FAW = 32'hA;
	localparam logic [31:0] MEM_MODE = 32'h0;
	typedef enum logic [4:0] {
		ST_CFG = 5'b00001,
		ST_SETTLE = 5'b00010,
		ST_IDLE = 5'b00100,
		ST_WR = 5'b01000,
		ST_RD = 5'b10000
	} adtt_state_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] len;
		logic [2:0] size;
		logic [1:0] burst;
	} adtt_addr_t;
	typedef struct packed {
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic psel;
		logic penable;
		logic pwrite;
	} adtt_apb_t;
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} adtt_avs_t;
endpackage : adtt_pkg

// ===== rtl/adtt_master.sv
// Purpose: Host-side burst master, config sequencer and latency counter
// Assumes: Memory subsystem AXI slave and APB config port on sys_clk
// Notes: Software commands and results travel over Avalon-MM registers
`timescale 1ns/100ps
module adtt_master (
	input wire logic sys_clk,
	input wire logic rst,
	input wire adtt_pkg::adtt_avs_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output adtt_pkg::adtt_apb_t apb_o,
	input wire logic apb_pready,
	input wire logic apb_pslverr,
	output adtt_pkg::adtt_addr_t aw_o,
	output logic awvalid,
	input wire logic awready,
	output logic [63:0] wdata,
	output logic [7:0] wstrb,
	output logic wlast,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output adtt_pkg::adtt_addr_t ar_o,
	output logic arvalid,
	input wire logic arready,
	input wire logic [63:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rlast,
	input wire logic rvalid,
	output logic rready,
	output logic err_n
);
	import adtt_pkg::*;

	function automatic logic [31:0] cfg_data(input logic [3:0] idx);
		logic [31:0] v;
		v = MEM_MODE;
		unique case (idx)
			4'h0: v = T_CAS;
			4'h1: v = T_RAS_MIN;
			4'h2: v = T_RAS_MAX;
			4'h3: v = T_RCD;
			4'h4: v = T_RP;
			4'h5: v = T_REFI;
			4'h6: v = T_RC;
			4'h7: v = T_RFC;
			4'h8: v = T_WR;
			4'h9: v = T_FAW;
			default: v = MEM_MODE;
		endcase
		return v;
	endfunction : cfg_data

	adtt_state_t state_r, state_nxt;
	adtt_apb_t apb_r;
	adtt_addr_t aw_r, ar_r;
	logic [3:0] cfg_idx_r;
	logic [12:0] settle_r;
	logic dir_r;
	logic [2:0] size_r;
	logic [8:0] nb_r, aw_cnt_r, w_cnt_r, b_cnt_r, ar_cnt_r, r_cnt_r;
	logic [3:0] beat_r;
	logic [63:0] wdata_r, exp_r;
	logic [31:0] cnt_r, rdata_r;
	logic awvalid_r, wvalid_r, wlast_r, arvalid_r, rdy_r;
	logic counting_r, done_r, err_n_r, berr_r, cfgerr_r, wait_r;

	// Bus and command decode
	wire bus_req = avs_req.read | avs_req.write;
	wire acc = bus_req & ~wait_r;
	wire [2:0] cmd_size = avs_req.writedata[CTRL_SIZE_LSB +: 3];
	wire cmd_dir = avs_req.writedata[CTRL_DIR];
	wire start = acc & avs_req.write & (avs_req.address == REG_CTRL)
		& avs_req.writedata[CTRL_START] & (state_r == ST_IDLE)
		& ~done_r & (cmd_size <= MAX_SIZE_CODE);
	wire start_wr = start & ~cmd_dir;
	wire start_rd = start & cmd_dir;
	wire [8:0] cmd_nb = 9'(MIN_BURSTS << cmd_size);
	wire rd_count = acc & avs_req.read & (avs_req.address == REG_COUNT);
	wire aw_hs = awvalid_r & awready;
	wire w_hs = wvalid_r & wready;
	wire b_hs = bvalid & rdy_r;
	wire ar_hs = arvalid_r & arready;
	wire r_hs = rvalid & rdy_r;
	wire w_end = w_hs & wlast_r & (w_cnt_r == nb_r - 9'h1);
	wire r_end = r_hs & rlast & (r_cnt_r == nb_r - 9'h1);
	wire wr_fin = (state_r == ST_WR) & (w_cnt_r == nb_r) & (b_cnt_r == nb_r);
	wire rd_fin = (state_r == ST_RD) & (r_cnt_r == nb_r);
	wire apb_step = apb_r.psel & apb_r.penable & apb_pready;
	wire cfg_last = apb_step & (cfg_idx_r == N_CFG - 4'h1);
	wire settled = (settle_r == SETTLE_CYC - 13'h1);
	wire ready = (state_r == ST_IDLE) | (state_r == ST_WR) | (state_r == ST_RD);
	wire busy = (state_r == ST_WR) | (state_r == ST_RD);
	wire [31:0] status_word = {26'h0, cfgerr_r, berr_r, ready, ~err_n_r, done_r, busy};
	wire [31:0] ctrl_word = {27'h0, size_r, dir_r, 1'b0};
	wire [31:0] rd_mux =
		(avs_req.address == REG_CTRL) ? ctrl_word :
		(avs_req.address == REG_STATUS) ? status_word :
		(avs_req.address == REG_COUNT) ? cnt_r :
		(avs_req.address == REG_BURSTS) ? {23'h0, nb_r} : 32'h0;

	// Memory is unusable until every tuned value is in and settling ends
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_CFG: if (cfg_last) state_nxt = ST_SETTLE;
			ST_SETTLE: if (settled) state_nxt = ST_IDLE;
			ST_IDLE: begin
				if (start_wr) state_nxt = ST_WR;
				else if (start_rd) state_nxt = ST_RD;
			end
			ST_WR: if (wr_fin) state_nxt = ST_IDLE;
			ST_RD: if (rd_fin) state_nxt = ST_IDLE;
			default: state_nxt = ST_CFG;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) state_r <= ST_CFG;
		else state_r <= state_nxt;
	end

	// Avalon slave: one wait cycle, then answer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
		end else begin
			wait_r <= ~(bus_req & wait_r);
			if (bus_req & wait_r) rdata_r <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dir_r <= 1'b0;
			size_r <= 3'h0;
			nb_r <= MIN_BURSTS;
		end else if (start) begin
			dir_r <= cmd_dir;
			size_r <= cmd_size;
			nb_r <= cmd_nb;
		end
	end

	// APB sequencer writes the tuned set, one setup and one access phase each
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			apb_r <= '{paddr: CFG_BASE, pwdata: 32'h0, psel: 1'b0, penable: 1'b0, pwrite: 1'b0};
			cfg_idx_r <= 4'h0;
		end else if (state_r == ST_CFG) begin
			if (!apb_r.psel) begin
				apb_r.psel <= 1'b1;
				apb_r.pwrite <= 1'b1;
				apb_r.paddr <= CFG_BASE + {6'h0, cfg_idx_r, 2'h0};
				apb_r.pwdata <= cfg_data(cfg_idx_r);
			end else if (!apb_r.penable) begin
				apb_r.penable <= 1'b1;
			end else if (apb_pready) begin
				apb_r.psel <= 1'b0;
				apb_r.penable <= 1'b0;
				apb_r.pwrite <= 1'b0;
				cfg_idx_r <= cfg_idx_r + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) cfgerr_r <= 1'b0;
		else if (apb_step & apb_pslverr) cfgerr_r <= 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) settle_r <= 13'h0;
		else if (state_r == ST_SETTLE) settle_r <= settle_r + 13'h1;
	end

	// Write addresses; next address goes out without waiting for B
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_r <= '{addr: 32'h0, len: AXI_LEN, size: AXI_SIZE, burst: AXI_INCR};
			awvalid_r <= 1'b0;
			aw_cnt_r <= 9'h0;
		end else if (start_wr) begin
			aw_r.addr <= 32'h0;
			awvalid_r <= 1'b1;
			aw_cnt_r <= 9'h0;
		end else if (aw_hs) begin
			aw_r.addr <= aw_r.addr + BURST_BYTES;
			aw_cnt_r <= aw_cnt_r + 9'h1;
			awvalid_r <= (aw_cnt_r + 9'h1 < nb_r);
		end
	end

	// Write data: incrementing pattern, 16 beats per burst
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wdata_r <= 64'h0;
			wvalid_r <= 1'b0;
			wlast_r <= 1'b0;
			beat_r <= 4'h0;
			w_cnt_r <= 9'h0;
		end else if (start_wr) begin
			wdata_r <= 64'h0;
			wvalid_r <= 1'b1;
			wlast_r <= 1'b0;
			beat_r <= 4'h0;
			w_cnt_r <= 9'h0;
		end else if (w_hs) begin
			wdata_r <= wdata_r + 64'h1;
			beat_r <= beat_r + 4'h1;
			wlast_r <= (beat_r == LAST_BEAT - 4'h1);
			if (wlast_r) begin
				w_cnt_r <= w_cnt_r + 9'h1;
				wvalid_r <= (w_cnt_r + 9'h1 < nb_r);
			end
		end
	end

	// Responses are watched alongside new bursts
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			b_cnt_r <= 9'h0;
			berr_r <= 1'b0;
		end else if (start) begin
			b_cnt_r <= 9'h0;
			berr_r <= 1'b0;
		end else if (b_hs) begin
			b_cnt_r <= b_cnt_r + 9'h1;
			if (bresp != 2'h0) berr_r <= 1'b1;
		end else if (r_hs & (rresp != 2'h0)) begin
			berr_r <= 1'b1;
		end
	end

	// Read addresses queue for as long as the slave keeps ARREADY up
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ar_r <= '{addr: 32'h0, len: AXI_LEN, size: AXI_SIZE, burst: AXI_INCR};
			arvalid_r <= 1'b0;
			ar_cnt_r <= 9'h0;
		end else if (start_rd) begin
			ar_r.addr <= 32'h0;
			arvalid_r <= 1'b1;
			ar_cnt_r <= 9'h0;
		end else if (ar_hs) begin
			ar_r.addr <= ar_r.addr + BURST_BYTES;
			ar_cnt_r <= ar_cnt_r + 9'h1;
			arvalid_r <= (ar_cnt_r + 9'h1 < nb_r);
		end
	end

	// Read check against the same pattern the writes laid down
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			exp_r <= 64'h0;
			r_cnt_r <= 9'h0;
			err_n_r <= 1'b1;
		end else if (start_rd) begin
			exp_r <= 64'h0;
			r_cnt_r <= 9'h0;
			err_n_r <= 1'b1;
		end else if (r_hs) begin
			exp_r <= exp_r + 64'h1;
			if (rdata != exp_r) err_n_r <= 1'b0;
			if (rlast) r_cnt_r <= r_cnt_r + 9'h1;
		end
	end

	// Always ready: throughput would suffer from any stall here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) rdy_r <= 1'b0;
		else rdy_r <= 1'b1;
	end

	// Latency counter, held until the next start command clears it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 32'h0;
			counting_r <= 1'b0;
		end else if (start) begin
			cnt_r <= 32'h0;
			counting_r <= 1'b1;
		end else if (counting_r) begin
			cnt_r <= cnt_r + 32'h1;
			if (w_end | r_end) counting_r <= 1'b0;
		end
	end

	// A finish in the same cycle as a fetch keeps the flag set
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) done_r <= 1'b0;
		else done_r <= wr_fin | rd_fin | (done_r & ~rd_count);
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign apb_o = apb_r;
	assign aw_o = aw_r;
	assign awvalid = awvalid_r;
	assign wdata = wdata_r;
	assign wstrb = {8{rdy_r}};
	assign wlast = wlast_r;
	assign wvalid = wvalid_r;
	assign bready = rdy_r;
	assign ar_o = ar_r;
	assign arvalid = arvalid_r;
	assign rready = rdy_r;
	assign err_n = err_n_r;
endmodule : adtt_master

// ===== verification/adtt_chk_assertions.sv
// Purpose: Port protocol checks for the throughput tester
// Assumes: One clock domain, rst active high
// Notes: Bound into every adtt_master instance
`timescale 1ns/100ps
module adtt_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire adtt_pkg::adtt_avs_t avs_req,
	input wire logic avs_waitrequest,
	input wire adtt_pkg::adtt_apb_t apb_o,
	input wire adtt_pkg::adtt_addr_t aw_o,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wlast,
	input wire logic wvalid,
	input wire logic wready,
	input wire adtt_pkg::adtt_addr_t ar_o,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic err_n
);
	import adtt_pkg::*;
	logic [31:0] aw_exp_r;
	logic [31:0] ar_exp_r;
	logic [3:0] beat_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_exp_r <= '0;
			ar_exp_r <= '0;
			beat_r <= '0;
		end else begin
			if (awvalid && awready)
				aw_exp_r <= aw_o.addr + BURST_BYTES;
			if (arvalid && arready)
				ar_exp_r <= ar_o.addr + BURST_BYTES;
			if (wvalid && wready)
				beat_r <= beat_r + 4'h1;
		end
	end
	wait_one_a: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("answer late");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	aw_hold_a: assert property (awvalid && !awready |=> awvalid && $stable(aw_o))
		else $error("write address dropped");
	aw_form_a: assert property (awvalid |-> aw_o.len == 8'h0F && aw_o.size == 3'h3
		&& aw_o.burst == 2'h1) else $error("write burst form");
	ar_form_a: assert property (arvalid |-> ar_o.len == 8'h0F && ar_o.size == 3'h3
		&& ar_o.burst == 2'h1) else $error("read burst form");
	aw_step_a: assert property (awvalid |-> aw_o.addr == 0 || aw_o.addr == aw_exp_r)
		else $error("write address step");
	ar_step_a: assert property (arvalid |-> ar_o.addr == 0 || ar_o.addr == ar_exp_r)
		else $error("read address step");
	wlast_beat_a: assert property (wvalid |-> wlast == (beat_r == 4'hF))
		else $error("wlast misplaced");
	err_cause_a: assert property ($fell(err_n) |-> $past(rvalid) || $past(rvalid, 2))
		else $error("error without read data");
	apb_setup_a: assert property (apb_o.psel && !apb_o.penable |=> apb_o.psel
		&& apb_o.penable) else $error("apb access phase");
	cover property (wvalid && wready && wlast);
	cover property (arvalid && arready);
	cover property ($fell(err_n));
endmodule : adtt_chk
bind adtt_master adtt_chk adtt_chk_inst (.*);

// ===== verification/adtt_mem_model.sv
// Purpose: Memory subsystem model: APB config port and AXI slave
// Assumes: Read data is the 64-bit beat index of the address
// Notes: Ready lines stall every other cycle to stress the master
`timescale 1ns/100ps
module adtt_mem_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic corrupt,
	input wire adtt_pkg::adtt_apb_t apb_o,
	output logic apb_pready,
	output logic apb_pslverr,
	input wire adtt_pkg::adtt_addr_t aw_o,
	input wire logic awvalid,
	output logic awready,
	input wire logic [63:0] wdata,
	input wire logic wlast,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire adtt_pkg::adtt_addr_t ar_o,
	input wire logic arvalid,
	output logic arready,
	output logic [63:0] rdata,
	output logic [1:0] rresp,
	output logic rlast,
	output logic rvalid,
	input wire logic rready
);
	import adtt_pkg::*;
	logic [31:0] cfg [0:15];
	logic [31:0] arq [0:7];
	logic [2:0] wp, rp;
	logic [3:0] rbeat;
	logic [63:0] rold;
	logic [31:0] awn, arn, wbeat;
	logic ph;
	int bad = 0;
	int ncfg, pend;
	assign apb_pslverr = 1'b0;
	assign bresp = 2'h0;
	assign rresp = 2'h0;
	assign apb_pready = apb_o.psel && apb_o.penable && ph;
	assign awready = ph;
	assign wready = !ph;
	assign bvalid = pend > 0;
	assign arready = ph && 3'(wp - rp) < 3'h4;
	assign rvalid = ph && wp != rp;
	assign rlast = rbeat == 4'hF;
	// Idle data is inverted so stale beats never look valid
	assign rdata = rvalid ? 64'(arq[rp] / 8 + rbeat) ^ 64'(corrupt && rbeat == 4'h5) : ~rold;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{ph, wp, rp, rbeat, rold, ncfg, pend} <= '0;
		end else begin
			ph <= !ph;
			pend <= pend + (wvalid && wready && wlast) - (bvalid && bready);
			if (clr)
				{awn, arn, wbeat} <= '0;
			if (apb_pready && apb_o.pwrite) begin
				cfg[apb_o.paddr[5:2]] <= apb_o.pwdata;
				ncfg <= ncfg + 1;
			end
			if (awvalid && awready) begin
				bad = bad + (aw_o.addr !== awn);
				awn <= awn + 128;
			end
			if (wvalid && wready) begin
				bad = bad + (wdata !== 64'(wbeat));
				wbeat <= wbeat + 1;
			end
			if (arvalid && arready) begin
				bad = bad + (ar_o.addr !== arn);
				arn <= arn + 128;
				arq[wp] <= ar_o.addr;
				wp <= wp + 3'h1;
			end
			if (rvalid && rready) begin
				rold <= rdata;
				rbeat <= rbeat + 4'h1;
				if (rlast)
					rp <= rp + 3'h1;
			end
		end
	end
endmodule : adtt_mem_model

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the throughput tester
// Assumes: 20 MHz sys_clk, Avalon master tasks below
// Notes: Latency is measured here and compared with COUNT
`timescale 1ns/100ps
module tb_top;
	import adtt_pkg::*;
	logic sys_clk = 0, rst = 1, clr = 0, corrupt = 0;
	adtt_avs_t avs_req = '0;
	adtt_apb_t apb_o;
	adtt_addr_t aw_o, ar_o;
	logic [31:0] avs_readdata, q;
	logic [63:0] wdata, rdata;
	logic [7:0] wstrb;
	logic [1:0] bresp, rresp;
	logic avs_waitrequest, apb_pready, apb_pslverr, awvalid, awready, wlast, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rlast, rvalid, rready, err_n, run = 0, act;
	int err_count = 0, checks = 0, meas, lasts, nb, cyc = 0;
	logic [31:0] tbl [0:10] = '{5, 12, 22528, 5, 5, 2592, 17, 54, 5, 10, 0};
	adtt_master adtt_master_inst (.*);
	adtt_mem_model adtt_mem_model_inst (.*);
	// Scaled stand-in for the fabric clock; memory clock ratio not modelled
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (run && (act || awvalid || arvalid)) begin
			act = 1;
			meas++;
			lasts += (wvalid && wready && wlast) || (rvalid && rready && rlast);
			if (lasts == nb)
				run = 0;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		avs_req <= '{a, !w, w, d};
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_req <= '0;
	endtask : bus
	task automatic poll(input int b);
		do bus(REG_STATUS, 0, 0); while (q[b] !== 1'b1);
	endtask : poll
	task automatic op(input logic dir, input logic [2:0] k, input logic bad);
		corrupt <= bad;
		clr <= 1;
		@(posedge sys_clk);
		clr <= 0;
		{meas, lasts, act} = '0;
		nb = 16 << k;
		run = 1;
		bus(REG_CTRL, 1, {27'h0, k, dir, 1'b1});
		poll(1);
		chk(32'(q[2]), 32'(bad));
		bus(REG_COUNT, 0, 0);
		chk(q, meas);
		bus(REG_COUNT, 0, 0);
		chk(q, meas);
		bus(REG_BURSTS, 0, 0);
		chk(q, nb);
		bus(REG_CTRL, 0, 0);
		chk(q, {27'h0, k, dir, 1'b0});
		chk(32'(wstrb), 32'hFF);
		chk(32'(err_n), 32'(!bad));
		chk(adtt_mem_model_inst.bad, 0);
	endtask : op
	task automatic finish_test;
		if (err_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	initial begin
		repeat (10) @(posedge sys_clk);
		chk(32'(avs_waitrequest), 1);
		chk(32'(err_n), 1);
		rst <= 0;
		bus(REG_CTRL, 1, 32'h1);
		bus(REG_STATUS, 1, 32'hF);
		bus(REG_STATUS, 0, 0);
		chk(q & 32'h3, 0);
		poll(3);
		chk(32'(cyc > 4000), 1);
		chk(adtt_mem_model_inst.ncfg, 11);
		for (int i = 0; i < 11; i++)
			chk(adtt_mem_model_inst.cfg[i], tbl[i]);
		for (int k = 0; k < 5; k++)
			op(0, 3'(k), 0);
		op(1, 0, 0);
		op(1, 1, 1);
		op(1, 0, 0);
		finish_test();
	end
	initial begin
		repeat (80000) @(posedge sys_clk);
		err_count++;
		finish_test();
	end
endmodule : tb_top
